// >>> core/rtcc_core.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module rtcc_core #(
	parameter int COUNT_WIDTH = 16
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rtc_kernel_clock,
	output logic calibrated_tick,
	input wire logic ts_capture,
	input wire rtcc_pkg::rtcc_date_t calendar_date,
	input wire logic [COUNT_WIDTH-1:0] prescaler_count,
	input wire logic [14:0] sync_divider_setting,
	output logic subsecond_past_divider,
	output logic [14:0] fraction_numerator
);
	import rtcc_pkg::*;

	// Elaboration checks: the snapshot and slot logic assume these sizes
	if (COUNT_WIDTH != 16) begin
		$error("rtcc_core: COUNT_WIDTH must be 16");
	end
	if (SLOT_BITS != 9) begin
		$error("rtcc_core: slot field must be 9 bits wide");
	end
	if (WINDOW_BITS <= INSERT_BITS) begin
		$error("rtcc_core: window must be longer than the insert period");
	end

	// ==========================================
	// Helpers
	// Bit reversal spreads the masked slots evenly over a window
	function automatic logic [SLOT_BITS-1:0] rev_slot(input logic [SLOT_BITS-1:0] s);
		logic [SLOT_BITS-1:0] r;
		r = '0;
		for (int i = 0; i < SLOT_BITS; i++) begin
			r[i] = s[SLOT_BITS-1-i];
		end
		return r;
	endfunction

	// Applies the period bits to a written calibration word
	function automatic rtcc_calib_t clean_calib(input logic [31:0] w);
		rtcc_calib_t c;
		c.rate_increase_bit = w[RATE_INC_POS];
		c.eight_second_period_bit = w[EIGHT_SEC_POS];
		c.sixteen_second_period_bit = w[SIXTEEN_SEC_POS] & ~w[EIGHT_SEC_POS];
		c.mask_pulse_count = w[MASK_COUNT_POS +: 9];
		if (w[EIGHT_SEC_POS]) begin
			c.mask_pulse_count[1:0] = 2'h0;
		end else if (w[SIXTEEN_SEC_POS]) begin
			c.mask_pulse_count[0] = 1'h0;
		end
		return c;
	endfunction

	// Places the captured date fields into the snapshot layout; reserved bits stay zero
	function automatic logic [31:0] pack_date(input rtcc_date_t d);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[YEAR_TENS_POS +: 4] = d.year_tens_digit;
		w[YEAR_UNITS_POS +: 4] = d.year_units_digit;
		w[WEEKDAY_POS +: 3] = d.weekday_code;
		w[MONTH_TENS_POS] = d.month_tens_digit;
		w[MONTH_UNITS_POS +: 4] = d.month_units_digit;
		w[DAY_TENS_POS +: 2] = d.day_tens_digit;
		w[DAY_UNITS_POS +: 4] = d.day_units_digit;
		return w;
	endfunction

	// ==========================================
	// APB decode
	logic wr_access;
	logic rd_access;
	logic addr_hit;
	logic first_access;
	logic ack_reg;
	logic [31:0] prdata_reg;
	logic [31:0] tsd_reg;
	logic [31:0] tsss_reg;
	rtcc_calib_t calib_reg;
	logic [31:0] prdata_next;

	// One wait state: read data is registered in the first access cycle,
	// so pready rises in the second and the write lands at the edge ending it
	assign first_access = psel & penable & ~ack_reg;
	assign pready = ack_reg;
	assign wr_access = ack_reg & psel & penable & pwrite;
	assign rd_access = first_access & ~pwrite;
	assign addr_hit = (paddr == TSD_OFFSET) || (paddr == TSSS_OFFSET) || (paddr == CALIB_OFFSET);
	assign pslverr = ack_reg & psel & penable & ~addr_hit;

	// Acknowledge flop; drops again after the completing edge
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ack_reg <= 1'h0;
		end else begin
			ack_reg <= first_access;
		end
	end

	// Read mux; reserved bits read as zero
	always_comb begin
		prdata_next = 32'h0000_0000;
		unique case (paddr)
			TSD_OFFSET: prdata_next = tsd_reg;
			TSSS_OFFSET: prdata_next = tsss_reg;
			CALIB_OFFSET: begin
				prdata_next[RATE_INC_POS] = calib_reg.rate_increase_bit;
				prdata_next[EIGHT_SEC_POS] = calib_reg.eight_second_period_bit;
				prdata_next[SIXTEEN_SEC_POS] = calib_reg.sixteen_second_period_bit;
				prdata_next[MASK_COUNT_POS +: 9] = calib_reg.mask_pulse_count;
			end
			default: prdata_next = 32'h0000_0000;
		endcase
	end

	// Registered read data, standing while pready is high
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prdata_reg <= 32'h0000_0000;
		end else begin
			prdata_reg <= rd_access ? prdata_next : 32'h0000_0000;
		end
	end

	assign prdata = prdata_reg;

	// ==========================================
	// Calibration control register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			calib_reg <= clean_calib(CALIB_RESET);
		end else if (wr_access && paddr == CALIB_OFFSET) begin
			calib_reg <= clean_calib(pwdata);
		end
	end

	// ==========================================
	// Timestamp snapshots
	// Date snapshot, loaded only by the capture event
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tsd_reg <= TSD_RESET;
		end else if (ts_capture) begin
			tsd_reg <= pack_date(calendar_date);
		end
	end

	// Sub-second snapshot, same event, writes never touch it
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tsss_reg <= TSSS_RESET;
		end else if (ts_capture) begin
			tsss_reg <= {16'h0000, prescaler_count};
		end
	end

	// Fraction numerator and shift indication from the snapshot
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			subsecond_past_divider <= 1'h0;
			fraction_numerator <= 15'h0000;
		end else begin
			subsecond_past_divider <= tsss_reg[15:0] > {1'h0, sync_divider_setting};
			fraction_numerator <= sync_divider_setting - tsss_reg[14:0];
		end
	end

	// ==========================================
	// Kernel clock sampling
	logic kclk_meta_reg;
	logic kclk_sync_reg;
	logic kclk_prev_reg;
	logic kclk_rise;

	// Two-flop synchroniser; the first flop feeds only the second
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			kclk_meta_reg <= 1'h0;
			kclk_sync_reg <= 1'h0;
			kclk_prev_reg <= 1'h0;
		end else begin
			kclk_meta_reg <= rtc_kernel_clock;
			kclk_sync_reg <= kclk_meta_reg;
			kclk_prev_reg <= kclk_sync_reg;
		end
	end

	assign kclk_rise = kclk_sync_reg & ~kclk_prev_reg;

	// ==========================================
	// Smooth calibration
	logic [WINDOW_BITS-1:0] pulse_cnt_reg;
	logic [SLOT_BITS-1:0] slot_rev;
	logic [8:0] slot_index;
	logic slot_point;
	logic mask_now;
	logic insert_now;
	logic insert_pend_reg;

	// Counts raw kernel pulses; wraps every 2^20 pulses (32 s nominal)
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pulse_cnt_reg <= '0;
		end else if (kclk_rise) begin
			pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
		end
	end

	// One candidate mask slot per 2^11 pulses, 512 slots per window
	assign slot_point = &pulse_cnt_reg[INSERT_BITS-1:0];
	assign slot_rev = rev_slot(pulse_cnt_reg[WINDOW_BITS-1:INSERT_BITS]);

	// Slot order for the chosen period; shorter windows repeat the pattern
	always_comb begin
		slot_index = slot_rev;
		if (calib_reg.eight_second_period_bit) begin
			slot_index = {slot_rev[8:2], 2'h0};
		end else if (calib_reg.sixteen_second_period_bit) begin
			slot_index = {slot_rev[8:1], 1'h0};
		end
	end

	// Mask count pulses out of each 2^20; each period bit repeats its window
	assign mask_now = kclk_rise & slot_point
		& (slot_index < calib_reg.mask_pulse_count);
	assign insert_now = kclk_rise & calib_reg.rate_increase_bit
		& (pulse_cnt_reg[INSERT_BITS-1:0] == '0);

	// Extra pulse goes out one system cycle after the real one
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			insert_pend_reg <= 1'h0;
		end else begin
			insert_pend_reg <= insert_now;
		end
	end

	// Calibrated tick to the prescaler
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			calibrated_tick <= 1'h0;
		end else begin
			calibrated_tick <= (kclk_rise & ~mask_now) | insert_pend_reg;
		end
	end

endmodule

`default_nettype wire

// >>> core/rtcc_pkg.sv
package rtcc_pkg;
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] TSD_OFFSET = 8'h34;
	localparam logic [7:0] TSSS_OFFSET = 8'h38;
	localparam logic [7:0] CALIB_OFFSET = 8'h3c;
	// ==========================================
	// Reset values
	localparam logic [31:0] TSD_RESET = 32'h0000_0000;
	localparam logic [31:0] TSSS_RESET = 32'h0000_0000;
	localparam logic [31:0] CALIB_RESET = 32'h0000_0000;
	// ==========================================
	// Field positions
	localparam int YEAR_TENS_POS = 20;
	localparam int YEAR_UNITS_POS = 16;
	localparam int WEEKDAY_POS = 13;
	localparam int MONTH_TENS_POS = 12;
	localparam int MONTH_UNITS_POS = 8;
	localparam int DAY_TENS_POS = 4;
	localparam int DAY_UNITS_POS = 0;
	localparam int RATE_INC_POS = 15;
	localparam int EIGHT_SEC_POS = 14;
	localparam int SIXTEEN_SEC_POS = 13;
	localparam int MASK_COUNT_POS = 0;
	// ==========================================
	// Calibration timing, in kernel clock pulses
	localparam int RTC_NOMINAL_HZ = 32768;
	localparam int WINDOW_BITS = 20;
	localparam int INSERT_BITS = 11;
	localparam int SLOT_BITS = WINDOW_BITS - INSERT_BITS;
	// ==========================================
	// Captured date, as delivered by the calendar
	typedef struct packed {
		logic [3:0] year_tens_digit;
		logic [3:0] year_units_digit;
		logic [2:0] weekday_code;
		logic month_tens_digit;
		logic [3:0] month_units_digit;
		logic [1:0] day_tens_digit;
		logic [3:0] day_units_digit;
	} rtcc_date_t;
	// Calibration control fields
	typedef struct packed {
		logic rate_increase_bit;
		logic eight_second_period_bit;
		logic sixteen_second_period_bit;
		logic [8:0] mask_pulse_count;
	} rtcc_calib_t;
endpackage

// >>> bench/rtcc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module rtcc_chk import rtcc_pkg::*; #(
	parameter int COUNT_WIDTH = 16
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic ts_capture,
	input wire rtcc_pkg::rtcc_date_t calendar_date,
	input wire logic [COUNT_WIDTH-1:0] prescaler_count,
	input wire logic [14:0] sync_divider_setting,
	input wire logic subsecond_past_divider,
	input wire logic [14:0] fraction_numerator
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Read access in progress
	wire logic rd = psel && penable && !pwrite && pready;
	logic [31:0] exp_date;
	logic [15:0] exp_sub;
	// Expected snapshot contents, rebuilt from the capture inputs
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			exp_date <= 32'h0000_0000;
			exp_sub <= 16'h0000;
		end else if (ts_capture) begin
			exp_date <= {8'h00, calendar_date.year_tens_digit, calendar_date.year_units_digit,
				calendar_date.weekday_code, calendar_date.month_tens_digit,
				calendar_date.month_units_digit, 2'h0, calendar_date.day_tens_digit,
				calendar_date.day_units_digit};
			exp_sub <= prescaler_count;
		end
	end
	AST_DATE: assert property (rd && paddr == 8'h34 |->
		prdata == exp_date) else $error("date snapshot wrong");
	AST_SUB: assert property (rd && paddr == 8'h38 |->
		prdata == {16'h0000, exp_sub}) else $error("subsecond snapshot wrong");
	AST_FRAC: assert property (ts_capture ##1 !ts_capture |=>
		fraction_numerator == 15'($past(sync_divider_setting) - $past(prescaler_count[14:0], 2)))
		else $error("fraction wrong");
	AST_PASTDIV: assert property (ts_capture ##1 !ts_capture |=>
		subsecond_past_divider == ($past(prescaler_count, 2) > {1'b0, $past(sync_divider_setting)}))
		else $error("past divider flag wrong");
	AST_CW8: assert property (rd && paddr == 8'h3c && prdata[14] |->
		prdata[1:0] == 2'h0 && !prdata[13]) else $error("eight second mask bits set");
	AST_SIXTEEN_SECOND_PERIOD_BIT: assert property (rd && paddr == 8'h3c && prdata[13] |->
		!prdata[0] && !prdata[14]) else $error("sixteen second mask bit set");
	AST_RSVD: assert property (rd && paddr == 8'h34 |->
		prdata[7:6] == 2'h0 && prdata[31:24] == 8'h00) else $error("reserved date bits set");
	AST_HOLD: assert property ($past(resetn, 2) && !ts_capture ##1 !ts_capture &&
		$stable(sync_divider_setting) |=> $stable(fraction_numerator)) else $error("snapshot moved");
endmodule
bind rtcc_core rtcc_chk #(.COUNT_WIDTH(COUNT_WIDTH)) chk (.*);
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rtcc_pkg::*;
	logic clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic rtc_kernel_clock = 1'b0, ts_capture = 1'b0, err, pready, pslverr;
	logic calibrated_tick, subsecond_past_divider;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	rtcc_date_t calendar_date = '0;
	logic [15:0] prescaler_count = '0;
	logic [14:0] sync_divider_setting = 15'h00ff, fraction_numerator;
	int fail_count = 0, n_tests = 0, ticks = 0;
	rtcc_core dut (.*);
	// ==========
	// Clock and tick count
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (calibrated_tick === 1'b1) ticks <= ticks + 1;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (fail_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One bus transfer, waiting on pready within a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			give_verdict();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic capture(input logic [15:0] cnt, input rtcc_date_t dt);
		@(posedge clk_sys);
		prescaler_count <= cnt;
		calendar_date <= dt;
		ts_capture <= 1'b1;
		@(posedge clk_sys);
		ts_capture <= 1'b0;
		calendar_date <= '0;
	endtask
	task automatic t_reset();
		for (int k = 0; k < 3; k++) begin
			apb(1'b0, 8'h34 + 8'(4 * k), '0);
			check(rd, 32'h0);
		end
	endtask
	// Weekday codes 1 to 7, with a write to the read-only snapshot between
	task automatic t_capture();
		for (int w = 1; w < 8; w++) begin
			capture(16'(w), '{4'h2, 4'h5, 3'(w), 1'b1, 4'h2, 2'h3, 4'h1});
			apb(1'b0, 8'h38, '0);
			check(rd, 32'(w));
			apb(1'b1, 8'h34, 32'h00ff_ff3f);
			apb(1'b0, 8'h34, '0);
			check(rd, 32'h0025_1231 | (32'(w) << 13));
		end
	endtask
	task automatic t_frac(input logic [15:0] cnt, input logic past);
		capture(cnt, '{4'h9, 4'h9, 3'h7, 1'b0, 4'h9, 2'h2, 4'h8});
		apb(1'b0, 8'h34, '0);
		check(32'(subsecond_past_divider), 32'(past));
		check(32'(fraction_numerator), 32'(15'h00ff - cnt[14:0]));
	endtask
	task automatic t_calib();
		logic [31:0] wv[4] = '{32'h81ff, 32'h61ff, 32'h21ff, 32'h0};
		logic [31:0] ev[4] = '{32'h81ff, 32'h41fc, 32'h21fe, 32'h0};
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, 8'h3c, wv[k]);
			apb(1'b0, 8'h3c, '0);
			check(rd, ev[k]);
		end
		apb(1'b0, 8'h40, '0);
		check(32'(err), 32'h1);
	endtask
	// One full 2^11 block of kernel pulses, counting calibrated ticks
	task automatic t_cal(input logic [31:0] cfg, input int exp);
		int t0;
		apb(1'b1, 8'h3c, cfg);
		t0 = ticks;
		repeat (2048) begin
			repeat (4) @(posedge clk_sys);
			rtc_kernel_clock <= 1'b1;
			repeat (4) @(posedge clk_sys);
			rtc_kernel_clock <= 1'b0;
		end
		repeat (8) @(posedge clk_sys);
		check(32'(ticks - t0), 32'(exp));
	endtask
	// ==========
	// Main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_capture();
		t_frac(16'h8005, 1'b1);
		t_frac(16'h0010, 1'b0);
		t_calib();
		t_cal(32'h8000, 2049);
		t_cal(32'h01ff, 2047);
		t_cal(32'h81ff, 2048);
		give_verdict();
	end
endmodule
`default_nettype wire
